// [core/srtc_pkg.sv]
// constants for the serial clock/calendar register interface
// assumes a 125 MHz system clock; bus pins are synchronised inside
package srtc_pkg;
	localparam int          SRTC_NUM_REGS     = 8;
	localparam logic [6:0]  SRTC_SLAVE_ADDR   = 7'h68;   // address byte D0h with r/w low
	localparam logic [2:0]  SRTC_OFF_SECONDS  = 3'h0;
	localparam logic [2:0]  SRTC_OFF_MINUTES  = 3'h1;
	localparam logic [2:0]  SRTC_OFF_CENT_HRS = 3'h2;
	localparam logic [2:0]  SRTC_OFF_WEEKDAY  = 3'h3;
	localparam logic [2:0]  SRTC_OFF_DATE     = 3'h4;
	localparam logic [2:0]  SRTC_OFF_MONTH    = 3'h5;
	localparam logic [2:0]  SRTC_OFF_YEAR     = 3'h6;
	localparam logic [2:0]  SRTC_OFF_CONTROL  = 3'h7;
	localparam logic [2:0]  SRTC_LAST_OFF     = 3'h7;
	// field positions
	localparam int          SRTC_BIT_OSC_STOP = 7;
	localparam int          SRTC_BIT_CENT_EN  = 7;
	localparam int          SRTC_BIT_CENT     = 6;
	localparam int          SRTC_BIT_OUT_LVL  = 7;
	localparam int          SRTC_BIT_FREQ_TST = 6;
	localparam int          SRTC_BIT_CAL_SIGN = 5;
	// field masks of writable bits
	localparam logic [7:0]  SRTC_MASK_SECONDS = 8'hFF;
	localparam logic [7:0]  SRTC_MASK_MINUTES = 8'h7F;
	localparam logic [7:0]  SRTC_MASK_CENT_HRS= 8'hFF;
	localparam logic [7:0]  SRTC_MASK_WEEKDAY = 8'h07;
	localparam logic [7:0]  SRTC_MASK_DATE    = 8'h3F;
	localparam logic [7:0]  SRTC_MASK_MONTH   = 8'h1F;
	localparam logic [7:0]  SRTC_MASK_YEAR    = 8'hFF;
	localparam logic [7:0]  SRTC_MASK_CONTROL = 8'hFF;
	// reset values
	localparam logic [7:0]  SRTC_RST_ZERO     = 8'h00;
	localparam logic [7:0]  SRTC_RST_ONE      = 8'h01;
	localparam logic [7:0]  SRTC_RST_CONTROL  = 8'h80;
	// bcd limits
	localparam logic [7:0]  SRTC_BCD_59       = 8'h59;
	localparam logic [7:0]  SRTC_BCD_23       = 8'h23;
	localparam logic [7:0]  SRTC_BCD_07       = 8'h07;
	localparam logic [7:0]  SRTC_BCD_31       = 8'h31;
	localparam logic [7:0]  SRTC_BCD_12       = 8'h12;
	localparam logic [7:0]  SRTC_BCD_99       = 8'h99;
	// one second tick at the system clock
	localparam int          SRTC_CLK_HZ       = 125000000;
	localparam int          SRTC_SEC_MS       = 1000;
	localparam int          SRTC_SEC_CYCLES   = SRTC_CLK_HZ / 1000 * SRTC_SEC_MS;
	localparam int          SRTC_FIFO_DEPTH   = 32;
	localparam int          SRTC_FIFO_WIDTH   = 11;
endpackage

// [core/srtc_fifo.sv]
// synchronous fifo between the serial front end and the register file
// assumes one clock domain; storage is flip-flops indexed by pointer
`timescale 1ns/1ns
module srtc_fifo
	import srtc_pkg::*;
#(
	parameter int WIDTH = SRTC_FIFO_WIDTH,
	parameter int DEPTH = SRTC_FIFO_DEPTH
)(
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             reset_n_i,
	input  wire logic             flush_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wr;
		logic [AW:0]                 rd;
	} srtc_fifo_s;

	srtc_fifo_s st_ff;
	srtc_fifo_s nxt_st;
	logic       full;
	logic       empty;

	// full when pointers differ only in the wrap bit
	assign full        = (st_ff.wr[AW] != st_ff.rd[AW]) && (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]);
	assign empty       = (st_ff.wr == st_ff.rd);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = st_ff.mem[st_ff.rd[AW-1:0]];

	// pointer and storage update
	always_comb
	begin
		nxt_st = st_ff;
		if (in_valid_i && !full)
		begin
			nxt_st.mem[st_ff.wr[AW-1:0]] = in_data_i;
			nxt_st.wr = st_ff.wr + 1'b1;
		end
		if (out_ready_i && !empty)
			nxt_st.rd = st_ff.rd + 1'b1;
		if (flush_i)
			nxt_st.rd = nxt_st.wr; // aborted traffic is discarded
	end

	// state register
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule // srtc_fifo

// [core/srtc_core.sv]
// two-wire slave interface and bcd clock/calendar register file
// assumes bus pins arrive asynchronously; supply-fail comes from a comparator
//
// Contract
// - respond only to address byte D0h; the code answers D1h for reads as well
// - eight registers seconds through control in order
// - pointer advances after every data byte
// - supply fail aborts access, clears pointer
// - ignore bus inputs while supply failed
// - resume bus recognition after supply returns
// - time fields bcd within legal ranges
// - century flag toggles only when enabled
// - seconds: stop flag, tens, units
// - control: level, test, sign, calibration magnitude
// - data change during clock high is control
// - idle when both lines high
// - falling data with clock high is start
// - rising data with clock high is stop
// - sample data while clock high
// - unlimited data bytes per transfer
// - eight-bit bytes plus ninth acknowledge slot
// - pull data low through acknowledge high phase
// - release data after master's missing acknowledge
`timescale 1ns/1ns
module srtc_core
	import srtc_pkg::*;
#(
	parameter int SEC_CYCLES = SRTC_SEC_CYCLES
)(
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       reset_n_i,
	// two-wire bus
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	// supply monitor
	input  wire logic       supply_fail_i,
	// output pin, open drain
	output logic            test_or_level_output_pin_o,
	output logic            test_or_level_output_pin_oe_n_o,
	// status
	output logic            bus_busy_o
);
	typedef enum logic [2:0] {
		SRTC_IDLE, SRTC_ADDR, SRTC_ADDR_ACK, SRTC_WR_BYTE, SRTC_WR_ACK,
		SRTC_RD_BYTE, SRTC_RD_ACK
	} srtc_state_e;

	typedef struct packed {
		logic [1:0]                   scl_sync;
		logic [1:0]                   sda_sync;
		logic [1:0]                   pf_sync;
		logic                         scl_d;
		logic                         sda_d;
		srtc_state_e                  state;
		logic [3:0]                   bit_cnt;
		logic [7:0]                   shreg;
		logic                         first;   // next written byte sets pointer
		logic                         rd_mode;
		logic [2:0]                   ptr;
		logic                         sda_out;
		logic                         busy;
		logic [SRTC_NUM_REGS-1:0][7:0] regs;
		logic [31:0]                  tick;
		logic                         pin;
	} srtc_core_s;

	srtc_core_s st_ff;
	srtc_core_s nxt_st;

	// fifo carries write {addr,data} from front end to register file
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [10:0] fifo_out_data;
	logic        fifo_push;
	logic [10:0] fifo_push_data;
	logic        fifo_pop;

	// synchronised views
	logic scl;
	logic sda;
	logic pf;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	assign scl        = st_ff.scl_sync[1];
	assign sda        = st_ff.sda_sync[1];
	assign pf         = st_ff.pf_sync[1];
	assign scl_rise   = !pf && scl && !st_ff.scl_d;
	assign scl_fall   = !pf && !scl && st_ff.scl_d;
	assign start_cond = !pf && scl && st_ff.scl_d && st_ff.sda_d && !sda;
	assign stop_cond  = !pf && scl && st_ff.scl_d && !st_ff.sda_d && sda;
	assign fifo_pop   = fifo_out_valid;

	srtc_fifo #(
		.WIDTH(SRTC_FIFO_WIDTH),
		.DEPTH(SRTC_FIFO_DEPTH)
	) u_fifo (
		.clock_i    (clock_i),
		.reset_n_i  (reset_n_i),
		.flush_i    (1'b0),
		.in_valid_i (fifo_push),
		.in_ready_o (fifo_in_ready),
		.in_data_i  (fifo_push_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o (fifo_out_data)
	);

	// bcd increment with wrap; returns carry when incrementing from the limit
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lim,
		input logic [7:0] low);
		logic [7:0] r;
		r = v;
		if (v >= lim)
			return {1'b1, low};
		if (v[3:0] >= 4'h9)
			r = {v[7:4] + 4'h1, 4'h0};
		else
			r = {v[7:4], v[3:0] + 4'h1};
		return {1'b0, r};
	endfunction

	// days in current month, bcd; leap years every fourth year
	function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8));
		case (mon)
			8'h02:   return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return SRTC_BCD_31;
		endcase
	endfunction

	// bus front end and register file
	always_comb
	begin
		logic [8:0] r;
		logic [2:0] wa;
		logic       carry;
		r     = '0;
		wa    = '0;
		carry = 1'b0;
		nxt_st = st_ff;
		fifo_push      = 1'b0;
		fifo_push_data = '0;
		nxt_st.scl_sync = {st_ff.scl_sync[0], scl_i};
		nxt_st.sda_sync = {st_ff.sda_sync[0], sda_i};
		nxt_st.pf_sync  = {st_ff.pf_sync[0], supply_fail_i};
		nxt_st.scl_d    = scl;
		nxt_st.sda_d    = sda;

		if (pf)
		begin
			nxt_st.state   = SRTC_IDLE;
			nxt_st.ptr     = '0;
			nxt_st.sda_out = 1'b1;
			nxt_st.busy    = 1'b0;
			nxt_st.scl_d   = 1'b1;       // no false edge when inputs return
			nxt_st.sda_d   = 1'b1;
		end
		else if (stop_cond)
		begin
			nxt_st.state   = SRTC_IDLE;
			nxt_st.sda_out = 1'b1;
			nxt_st.busy    = 1'b0;
		end
		else if (start_cond)
		begin
			nxt_st.state   = SRTC_ADDR;
			nxt_st.bit_cnt = '0;
			nxt_st.sda_out = 1'b1;
			nxt_st.busy    = 1'b1;
		end
		else
		begin
			case (st_ff.state)
				SRTC_ADDR, SRTC_WR_BYTE:
				begin
					if (scl_rise)
					begin
						nxt_st.shreg   = {st_ff.shreg[6:0], sda};
						nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
					end
					if (scl_fall && st_ff.bit_cnt == 4'h8)
					begin
						nxt_st.bit_cnt = '0;
						if (st_ff.state == SRTC_ADDR)
						begin
							if (st_ff.shreg[7:1] == SRTC_SLAVE_ADDR)
							begin
								nxt_st.sda_out = 1'b0;
								nxt_st.rd_mode = st_ff.shreg[0];
								nxt_st.first   = 1'b1;
								nxt_st.state   = SRTC_ADDR_ACK;
							end
							else
								nxt_st.state = SRTC_IDLE;
						end
						else if (fifo_in_ready)
						begin
							nxt_st.sda_out = 1'b0;
							nxt_st.state   = SRTC_WR_ACK;
							if (st_ff.first)
								nxt_st.ptr = st_ff.shreg[2:0];
							else
							begin
								fifo_push      = 1'b1;
								fifo_push_data = {st_ff.ptr, st_ff.shreg};
								nxt_st.ptr     = st_ff.ptr + 3'h1;
							end
							nxt_st.first = 1'b0;
						end
						else
							nxt_st.state = SRTC_IDLE; // full: no acknowledge
					end
				end
				SRTC_ADDR_ACK, SRTC_WR_ACK:
				begin
					if (scl_fall) // ack held through the high phase
					begin
						if (st_ff.rd_mode)
						begin
							nxt_st.state   = SRTC_RD_BYTE;
							nxt_st.shreg   = st_ff.regs[st_ff.ptr];
							nxt_st.sda_out = st_ff.regs[st_ff.ptr][7];
							nxt_st.ptr     = st_ff.ptr + 3'h1;
							nxt_st.bit_cnt = 4'h1;
						end
						else
						begin
							nxt_st.state   = SRTC_WR_BYTE;
							nxt_st.sda_out = 1'b1;
						end
					end
				end
				SRTC_RD_BYTE:
				begin
					if (scl_fall)
					begin
						if (st_ff.bit_cnt == 4'h8)
						begin
							nxt_st.sda_out = 1'b1; // master acknowledges
							nxt_st.state   = SRTC_RD_ACK;
						end
						else
						begin
							nxt_st.sda_out = st_ff.shreg[6];
							nxt_st.shreg   = {st_ff.shreg[6:0], 1'b0};
							nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
						end
					end
				end
				SRTC_RD_ACK:
				begin
					if (scl_rise && sda)
						nxt_st.state = SRTC_IDLE; // no ack: leave line high
					else if (scl_fall)
					begin
						nxt_st.state   = SRTC_RD_BYTE;
						nxt_st.shreg   = st_ff.regs[st_ff.ptr];
						nxt_st.sda_out = st_ff.regs[st_ff.ptr][7];
						nxt_st.ptr     = st_ff.ptr + 3'h1;
						nxt_st.bit_cnt = 4'h1;
					end
				end
				default:
				begin
					nxt_st.sda_out = 1'b1;
					nxt_st.busy    = scl ? st_ff.busy : st_ff.busy; // idle until start
				end
			endcase
		end

		// timekeeping, halted while the stop flag is set
		nxt_st.tick = st_ff.tick + 32'h1;
		if (st_ff.tick >= SEC_CYCLES - 1)
		begin
			nxt_st.tick = '0;
			if (!st_ff.regs[SRTC_OFF_SECONDS][SRTC_BIT_OSC_STOP])
			begin
				r = bcd_inc({1'b0, st_ff.regs[SRTC_OFF_SECONDS][6:0]}, SRTC_BCD_59, SRTC_RST_ZERO);
				nxt_st.regs[SRTC_OFF_SECONDS][6:0] = r[6:0];
				carry = r[8];
				if (carry)
				begin
					r = bcd_inc(st_ff.regs[SRTC_OFF_MINUTES], SRTC_BCD_59, SRTC_RST_ZERO);
					nxt_st.regs[SRTC_OFF_MINUTES] = r[7:0];
					carry = r[8];
				end
				if (carry)
				begin
					r = bcd_inc({2'b00, st_ff.regs[SRTC_OFF_CENT_HRS][5:0]}, SRTC_BCD_23,
						SRTC_RST_ZERO);
					nxt_st.regs[SRTC_OFF_CENT_HRS][5:0] = r[5:0];
					carry = r[8];
				end
				if (carry)
				begin
					r = bcd_inc(st_ff.regs[SRTC_OFF_WEEKDAY], SRTC_BCD_07, SRTC_RST_ONE);
					nxt_st.regs[SRTC_OFF_WEEKDAY] = r[7:0];
					r = bcd_inc(st_ff.regs[SRTC_OFF_DATE],
						month_end(st_ff.regs[SRTC_OFF_MONTH], st_ff.regs[SRTC_OFF_YEAR]),
						SRTC_RST_ONE);
					nxt_st.regs[SRTC_OFF_DATE] = r[7:0];
					carry = r[8];
				end
				if (carry)
				begin
					r = bcd_inc(st_ff.regs[SRTC_OFF_MONTH], SRTC_BCD_12, SRTC_RST_ONE);
					nxt_st.regs[SRTC_OFF_MONTH] = r[7:0];
					carry = r[8];
				end
				if (carry)
				begin
					r = bcd_inc(st_ff.regs[SRTC_OFF_YEAR], SRTC_BCD_99, SRTC_RST_ZERO);
					nxt_st.regs[SRTC_OFF_YEAR] = r[7:0];
					if (r[8] && st_ff.regs[SRTC_OFF_CENT_HRS][SRTC_BIT_CENT_EN])
						nxt_st.regs[SRTC_OFF_CENT_HRS][SRTC_BIT_CENT] =
							!st_ff.regs[SRTC_OFF_CENT_HRS][SRTC_BIT_CENT];
				end
			end
		end

		// bus writes win over the tick in the same cycle; fields masked
		if (fifo_pop)
		begin
			wa = fifo_out_data[10:8];
			case (wa)
				SRTC_OFF_SECONDS:  nxt_st.regs[wa] = fifo_out_data[7:0] & SRTC_MASK_SECONDS;
				SRTC_OFF_MINUTES:  nxt_st.regs[wa] = fifo_out_data[7:0] & SRTC_MASK_MINUTES;
				SRTC_OFF_CENT_HRS: nxt_st.regs[wa] = fifo_out_data[7:0] & SRTC_MASK_CENT_HRS;
				SRTC_OFF_WEEKDAY:  nxt_st.regs[wa] = fifo_out_data[7:0] & SRTC_MASK_WEEKDAY;
				SRTC_OFF_DATE:     nxt_st.regs[wa] = fifo_out_data[7:0] & SRTC_MASK_DATE;
				SRTC_OFF_MONTH:    nxt_st.regs[wa] = fifo_out_data[7:0] & SRTC_MASK_MONTH;
				SRTC_OFF_YEAR:     nxt_st.regs[wa] = fifo_out_data[7:0] & SRTC_MASK_YEAR;
				default:           nxt_st.regs[wa] = fifo_out_data[7:0] & SRTC_MASK_CONTROL;
			endcase
			if (wa == SRTC_OFF_SECONDS)
				nxt_st.tick = '0; // writing seconds restarts the second
		end

		// level output; frequency test waveform not modelled, level used instead
		nxt_st.pin = st_ff.regs[SRTC_OFF_CONTROL][SRTC_BIT_OUT_LVL];
	end

	// state register
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st_ff          <= '0;
			st_ff.scl_sync <= 2'h3;
			st_ff.sda_sync <= 2'h3;
			st_ff.scl_d    <= 1'b1;
			st_ff.sda_d    <= 1'b1;
			st_ff.sda_out  <= 1'b1;
			st_ff.state    <= SRTC_IDLE;
			st_ff.regs[SRTC_OFF_WEEKDAY]  <= SRTC_RST_ONE;
			st_ff.regs[SRTC_OFF_DATE]     <= SRTC_RST_ONE;
			st_ff.regs[SRTC_OFF_MONTH]    <= SRTC_RST_ONE;
			st_ff.regs[SRTC_OFF_CONTROL]  <= SRTC_RST_CONTROL;
			st_ff.pin      <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	// open drain: enable low only when pulling the line down
	assign sda_o                           = 1'b0;
	assign sda_oe_n_o                      = st_ff.sda_out;
	assign test_or_level_output_pin_o      = 1'b0;
	assign test_or_level_output_pin_oe_n_o = st_ff.pin;
	assign bus_busy_o                      = st_ff.busy;
endmodule // srtc_core

// [tb/srtc_core_sva.sv]
// assertions on the two-wire slave ports of the register interface
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/1ns
module srtc_core_sva
	import srtc_pkg::*;
#(
	parameter int SEC_CYCLES = SRTC_SEC_CYCLES
)(
	// clock and reset
	input  wire logic clock_i,
	input  wire logic reset_n_i,
	// two-wire bus
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic sda_o,
	input  wire logic sda_oe_n_o,
	// supply monitor
	input  wire logic supply_fail_i,
	// output pin and status
	input  wire logic test_or_level_output_pin_o,
	input  wire logic test_or_level_output_pin_oe_n_o,
	input  wire logic bus_busy_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	// open-drain pins only ever pull low
	property p_open_drain;
		sda_o == 1'b0 && test_or_level_output_pin_o == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin drives high");
	// a held supply failure leaves the bus idle and released
	property p_fail_quiet;
		supply_fail_i [*6] |-> sda_oe_n_o && !bus_busy_o;
	endproperty
	a_fail_quiet: assert property (p_fail_quiet) else $error("active during failure");
	property p_start_busy;
		scl_i && $fell(sda_i) && !supply_fail_i |-> ##[1:6] bus_busy_o;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start missed");
	property p_stop_idle;
		scl_i && $rose(sda_i) |-> ##[1:6] !bus_busy_o;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop missed");
	// an idle device never holds the data line
	property p_release_idle;
		!bus_busy_o [*3] |-> sda_oe_n_o;
	endproperty
	a_release_idle: assert property (p_release_idle) else $error("idle drive");
	// the device moves data only while the clock is low
	property p_drive_scl_low;
		$changed(sda_oe_n_o) && !supply_fail_i |-> !scl_i;
	endproperty
	a_drive_scl_low: assert property (p_drive_scl_low) else $error("moved in high");
	property p_busy_cause;
		$rose(bus_busy_o) |-> $past(scl_i, 2) && !sda_i && !supply_fail_i;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
	// a pulled-low slot starts with the clock low and lasts at least nine cycles
	property p_ack_hold;
		disable iff (!reset_n_i || supply_fail_i)
		$fell(sda_oe_n_o) |-> !scl_i ##1 (!sda_oe_n_o) [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("low slot too short");
endmodule // srtc_core_sva

bind srtc_core srtc_core_sva #(.SEC_CYCLES(SEC_CYCLES)) u_sva (
	.clock_i(clock_i),
	.reset_n_i(reset_n_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o),
	.supply_fail_i(supply_fail_i),
	.test_or_level_output_pin_o(test_or_level_output_pin_o),
	.test_or_level_output_pin_oe_n_o(test_or_level_output_pin_oe_n_o),
	.bus_busy_o(bus_busy_o)
);

// [tb/srtc_master_model.sv]
// two-wire bus master model: owns the clock line, pulls data low
// assumes the bench resolves the pulled-up data wire from all parties
`timescale 1ns/1ns
module srtc_master_model (
	// bus, master side
	output logic      scl_o,
	output logic      sda_oe_n_o,
	input  wire logic sda_i
);
	int q = 40;   // quarter of a 160 ns bus clock
	int slow = 0; // extra low time for a slow master
	// idle with both lines high; clock stands still between frames
	initial
	begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	// start or repeated start: data falls with the clock high
	task automatic start();
		sda_oe_n_o = 1'b1;
		#(q);
		scl_o = 1'b1;
		#(q);
		sda_oe_n_o = 1'b0;
		#(q);
		scl_o = 1'b0;
	endtask
	// stop: data rises with the clock high
	task automatic stop();
		#(q);
		sda_oe_n_o = 1'b0;
		#(q);
		scl_o = 1'b1;
		#(q);
		sda_oe_n_o = 1'b1;
		#(q);
	endtask
	// one clock pulse per bit, data set low, sampled high
	task automatic bit_io(input logic b, output logic s);
		#(q + slow);
		sda_oe_n_o = b;
		#(q);
		scl_o = 1'b1;
		#(q);
		s = sda_i;
		#(q);
		scl_o = 1'b0;
	endtask
	// eight bits msb first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] tx, input logic ack,
		output logic [7:0] rx, output logic ack_in);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack, ack_in);
	endtask
endmodule // srtc_master_model

// [tb/srtc_core_tb.sv]
// self-checking bench: random register traffic over the two-wire bus
// assumes the master model and the checker bound to the core
`timescale 1ns/1ns
module srtc_core_tb;
	import srtc_pkg::*;
	localparam logic [7:0] WR = {SRTC_SLAVE_ADDR, 1'b0};
	localparam logic [7:0] RD = {SRTC_SLAVE_ADDR, 1'b1};
	localparam logic [7:0] RST_V [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80};
	// last second of a century-enabled year, and the calendar one tick later
	localparam logic [7:0] TK_V [7] = '{8'h59, 8'h59, 8'hA3, 8'h07, 8'h31, 8'h12, 8'h99};
	localparam logic [7:0] ROLL_V [7] = '{8'h00, 8'h00, 8'hC0, 8'h01, 8'h01, 8'h01, 8'h00};
	logic        clock_i;
	logic        reset_n_i;
	logic        supply_fail;
	logic        scl;
	logic        m_oe_n;
	logic        d_sda;
	logic        d_oe_n;
	logic        pin_oe_n;
	logic        busy;
	logic [7:0]  wq [48];
	logic [7:0]  rq [9];
	logic [7:0]  ex [8];
	logic        nk;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;
	int          p;
	wire         sda_w;
	// pulled-up wire, either side may pull it low
	assign sda_w = m_oe_n & (d_oe_n | d_sda);
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	// short second: every test but the rollover reads back well within one second of its seconds write
	srtc_core #(.SEC_CYCLES(20000)) dut (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.scl_i(scl),
		.sda_i(sda_w),
		.sda_o(d_sda),
		.sda_oe_n_o(d_oe_n),
		.supply_fail_i(supply_fail),
		.test_or_level_output_pin_o(),
		.test_or_level_output_pin_oe_n_o(pin_oe_n),
		.bus_busy_o(busy)
	);
	srtc_master_model m (.scl_o(scl), .sda_oe_n_o(m_oe_n), .sda_i(sda_w));
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard, well above the ~55k cycles the tests take
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			failures++;
			give_verdict();
		end
	end
	// random in-range bcd value for register r
	function automatic logic [7:0] legal(input int r);
		int v;
		case (r)
			0, 1:    v = $urandom_range(59);
			2:       v = $urandom_range(23);
			3:       v = $urandom_range(7, 1);
			4:       v = $urandom_range(31, 1);
			5:       v = $urandom_range(12, 1);
			6:       v = $urandom_range(99);
			default: return 8'($urandom);
		endcase
		return 8'((v / 10) * 16 + v % 10);
	endfunction
	// pointer byte then n queued bytes; nk collects refusals
	task automatic wr(input logic [7:0] adr, input logic [2:0] ptr, input int n);
		logic [7:0] x;
		logic       a;
		@(negedge clock_i);
		m.start();
		m.byte_io(adr, 1'b1, x, a);
		nk = a;
		m.byte_io({5'h00, ptr}, 1'b1, x, a);
		nk = nk | a;
		for (int i = 0; i < n; i++)
		begin
			m.byte_io(wq[i], 1'b1, x, a);
			nk = nk | a;
		end
		m.stop();
	endtask
	// read n bytes from the pointer; the last one is refused
	task automatic rd(input int n);
		logic [7:0] x;
		logic       a;
		@(negedge clock_i);
		m.start();
		m.byte_io(RD, 1'b1, x, a);
		check(11'(a), 11'h000);
		for (int i = 0; i < n; i++)
		begin
			m.byte_io(8'hFF, i == n - 1, x, a);
			rq[i] = x;
		end
		m.stop();
	endtask
	// main sequence, inputs moved at the falling edge
	initial
	begin
		reset_n_i = 1'b0;
		supply_fail = 1'b0;
		void'($urandom(94270));
		repeat (8) @(negedge clock_i);
		reset_n_i = 1'b1;
		repeat (4) @(negedge clock_i);
		wr(WR, 3'h0, 0);
		check(11'(nk), 11'h000);
		rd(9);
		for (int i = 0; i < 9; i++)
			check(11'(rq[i]), 11'(RST_V[i % 8]));
		check(11'(pin_oe_n), 11'h001);
		$display("test reset values done");
		// long burst crossing the fifo, then a slow read from a random pointer
		for (int i = 0; i < 44; i++)
		begin
			wq[i] = legal(i % 8);
			ex[i % 8] = wq[i];
		end
		wr(WR, 3'h0, 44);
		check(11'(nk), 11'h000);
		p = $urandom_range(7, 1);
		wr(WR, 3'(p), 0);
		m.slow = 400;
		rd(8);
		m.slow = 0;
		for (int i = 0; i < 8; i++)
			check(11'(rq[i]), 11'(ex[(p + i) % 8]));
		check(11'(pin_oe_n), 11'(ex[7][7]));
		$display("test burst done");
		repeat (3)
		begin
			do
				wq[0] = 8'($urandom);
			while (wq[0][7:1] == SRTC_SLAVE_ADDR);
			wr(wq[0], 3'h0, 0);
			check(11'(nk), 11'h001);
		end
		$display("test foreign address done");
		// supply failure in the middle of the pointer byte
		fork
			wr(WR, 3'h3, 2);
			begin
				#2288;
				supply_fail = 1'b1;
				repeat (8) @(negedge clock_i);
				check(11'({busy, d_oe_n}), 11'h001);
			end
		join
		check(11'(nk), 11'h001);
		supply_fail = 1'b0;
		repeat (80) @(negedge clock_i);
		rd(1);
		check(11'(rq[0]), 11'(ex[0]));
		wr(WR, 3'h0, 0);
		rd(8);
		for (int i = 0; i < 8; i++)
			check(11'(rq[i]), 11'(ex[i]));
		check(11'(busy), 11'h000);
		$display("test supply failure done");
		// long write through the internal queue from a random pointer
		p = $urandom_range(7);
		for (int i = 0; i < 40; i++)
		begin
			wq[i] = legal((p + i) % 8);
			ex[(p + i) % 8] = wq[i];
		end
		wr(WR, 3'(p), 40);
		check(11'(nk), 11'h000);
		wr(WR, 3'h0, 0);
		rd(8);
		for (int i = 0; i < 8; i++)
			check(11'(rq[i]), 11'(ex[i]));
		check(11'(pin_oe_n), 11'(ex[7][7]));
		check(11'(busy), 11'h000);
		$display("test queue done");
		// one tick carries through every field and flips the century flag
		for (int i = 0; i < 7; i++)
			wq[i] = TK_V[i];
		wr(WR, 3'h0, 7);
		check(11'(nk), 11'h000);
		repeat (19500) @(negedge clock_i);
		wr(WR, 3'h0, 0);
		rd(7);
		for (int i = 0; i < 7; i++)
			check(11'(rq[i]), 11'(ROLL_V[i]));
		$display("test rollover done");
		give_verdict();
	end
endmodule // srtc_core_tb
